// ---- sxpw_pkg.sv ----
// Constants, register map and field layout of the six-channel PWM generator core
// ==========================================================================
package sxpw_pkg;

  localparam int unsigned NUM_CH = 6;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLOCK_SOURCE_CONTROL = 8'h8e;
  localparam logic [7:0] IDX_PWM_RUN_CONTROL      = 8'hd8;
  localparam logic [7:0] IDX_PWM_MODE_CONFIG      = 8'hdf;
  localparam logic [7:0] IDX_PERIOD_LOW_BYTE      = 8'hd9;
  localparam logic [7:0] IDX_PERIOD_HIGH_BYTE     = 8'hd1;
  localparam logic [7:0] IDX_DUTY_LOW_BYTE [6]    = '{8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hcc, 8'hcd};
  localparam logic [7:0] IDX_DUTY_HIGH_BYTE [6]   = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hc4, 8'hc5};
  localparam logic [7:0] IDX_PIN_FUNCTION_SELECT  = 8'he0;
  localparam logic [7:0] IDX_IRQ_STATUS           = 8'he1;
  localparam logic [7:0] IDX_IRQ_MASK             = 8'he2;

  // Field positions
  localparam int unsigned BIT_CLOCK_SOURCE_SELECT = 6;
  localparam int unsigned BIT_RUN_ENABLE          = 7;
  localparam int unsigned BIT_LOAD                = 6;
  localparam int unsigned BIT_GENERATOR_FLAG      = 5;
  localparam int unsigned BIT_COUNTER_CLEAR       = 4;
  localparam int unsigned BIT_GROUP_MODE_ENABLE   = 5;
  localparam int unsigned BIT_IRQ_WRAP            = 0;
  localparam int unsigned BIT_IRQ_LOAD_DONE       = 1;

  // Writable bits of the clock source control register
  localparam logic [7:0] CLOCK_SOURCE_RW_MASK = 8'h5a;

  // Values after reset
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [15:0] RST_WORD  = 16'h0000;
  localparam logic [5:0]  RST_PINS  = 6'h00;
  localparam logic [1:0]  RST_IRQ   = 2'h0;
  localparam logic [6:0]  RST_DIV   = 7'h00;

endpackage

// ---- sxpw_wave_if.sv ----
// Carrier between the counter owner and the six comparators
`timescale 1ns/10ps
`default_nettype none
interface sxpw_wave_if;
  logic [15:0] count;
  logic [15:0] duty [6];
  logic [5:0]  wave;
  modport gen (output count, output duty, input wave);
  modport cmp (input count, input duty, output wave);
endinterface
`default_nettype wire

// ---- sxpw_prescaler.sv ----
// Clock source select and power-of-two prescaler producing counter ticks
`timescale 1ns/10ps
`default_nettype none
module sxpw_prescaler (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       srcSelect,
  input  wire logic       timer1Overflow,
  input  wire logic [2:0] prescale,
  // Tick out
  output logic            tick
);
  logic [6:0] divCnt;
  wire        srcPulse = srcSelect ? timer1Overflow : 1'b1;
  wire  [7:0] shifted  = 8'h01 << prescale;
  wire  [6:0] divMask  = 7'(shifted - 8'h01);
  wire        divHit   = srcPulse & ((divCnt & divMask) == divMask);
  wire  [6:0] next_divCnt = srcPulse ? 7'(divCnt + 7'h01) : divCnt;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      divCnt <= sxpw_pkg::RST_DIV;
      tick   <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      tick   <= divHit;
    end
  end

  property p_sys_every_cycle;
    @(posedge core_clk) disable iff (!rst_n)
    (!srcSelect && prescale == 3'h0) [*2] |=> tick;
  endproperty
  a_sys_every_cycle: assert property (p_sys_every_cycle) else $error("undivided system clock missed a tick");
endmodule
`default_nettype wire

// ---- sxpw_compare.sv ----
// Six edge-aligned comparators against the shared counter
`timescale 1ns/10ps
`default_nettype none
module sxpw_compare (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Counter and duties in, waves out
  sxpw_wave_if.cmp  wif
);
  for (genvar i = 0; i < 6; i++) begin : ch
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        wif.wave[i] <= 1'b0;
      end else begin
        wif.wave[i] <= (wif.count < wif.duty[i]);
      end
    end
  end

  property p_wave_follows_compare;
    @(posedge core_clk) disable iff (!rst_n)
    ##1 wif.wave[0] == $past(wif.count < wif.duty[0]);
  endproperty
  a_wave_follows_compare: assert property (p_wave_follows_compare) else $error("wave 0 not high below duty");
endmodule
`default_nettype wire

// ---- sxpw_core.sv ----
// Six-channel PWM generator core with APB register slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module sxpw_core (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer 1 overflow pulse, same clock
  input  wire logic        timer1Overflow,
  // Pins
  input  wire logic [5:0]  gpioOut,
  output logic      [5:0]  rawWave,
  output logic      [5:0]  pinOut,
  output logic      [5:0]  pinFunctionSelect,
  // Interrupt
  output logic             irq
);
  // ==========================================================================
  // Control registers
  logic [7:0]  clockSourceControl;
  logic [7:0]  modeConfig;
  logic        runEnable;
  logic        loadPending;
  logic        generatorFlag;
  logic        clearPending;
  logic [15:0] bufPeriod;
  logic [15:0] activePeriod;
  logic [15:0] count;
  logic [1:0]  irqStatus;
  logic [1:0]  irqMask;
  logic        tick;

  sxpw_wave_if wif ();

  // ==========================================================================
  // APB decode
  wire [7:0] regIdx     = paddr[9:2];
  wire       apbSetup   = psel & ~penable;
  wire       apbWrite   = psel & penable & pready & pwrite;
  wire [7:0] wByte      = pwdata[7:0];
  wire       hitClk     = regIdx == sxpw_pkg::IDX_CLOCK_SOURCE_CONTROL;
  wire       hitRun     = regIdx == sxpw_pkg::IDX_PWM_RUN_CONTROL;
  wire       hitMode    = regIdx == sxpw_pkg::IDX_PWM_MODE_CONFIG;
  wire       hitPerLo   = regIdx == sxpw_pkg::IDX_PERIOD_LOW_BYTE;
  wire       hitPerHi   = regIdx == sxpw_pkg::IDX_PERIOD_HIGH_BYTE;
  wire       hitPin     = regIdx == sxpw_pkg::IDX_PIN_FUNCTION_SELECT;
  wire       hitStat    = regIdx == sxpw_pkg::IDX_IRQ_STATUS;
  wire       hitMask    = regIdx == sxpw_pkg::IDX_IRQ_MASK;
  wire       addrInMap  = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
  wire [6:0] dutyHitAcc;
  wire [7:0] dutyReadAcc [7];

  // ==========================================================================
  // Counter sequencing
  wire groupMode  = modeConfig[sxpw_pkg::BIT_GROUP_MODE_ENABLE];
  wire countStep  = tick & runEnable & ~clearPending;
  wire wrapNow    = countStep & (count >= activePeriod);
  wire loadNow    = loadPending & wrapNow;
  wire [15:0] next_count = clearPending ? sxpw_pkg::RST_WORD :
                           wrapNow      ? sxpw_pkg::RST_WORD :
                           countStep    ? 16'(count + 16'h0001) : count;
  wire [1:0] irqEvents;
  assign irqEvents[sxpw_pkg::BIT_IRQ_WRAP]      = wrapNow;
  assign irqEvents[sxpw_pkg::BIT_IRQ_LOAD_DONE] = loadNow;
  wire [1:0] next_irqStatus = (irqStatus & ~((apbWrite & hitStat) ? wByte[1:0] : 2'h0)) | irqEvents;

  // ==========================================================================
  // Per-channel duty buffers and group mapping
  assign dutyHitAcc[0]  = 1'b0;
  assign dutyReadAcc[0] = 8'h00;
  for (genvar i = 0; i < 6; i++) begin : ch
    logic [15:0] bufDuty;
    logic [15:0] activeDuty;
    wire hitLo = regIdx == sxpw_pkg::IDX_DUTY_LOW_BYTE[i];
    wire hitHi = regIdx == sxpw_pkg::IDX_DUTY_HIGH_BYTE[i];
    assign dutyHitAcc[i+1]  = dutyHitAcc[i] | hitLo | hitHi;
    assign dutyReadAcc[i+1] = dutyReadAcc[i] | (hitLo ? bufDuty[7:0] : 8'h00) | (hitHi ? bufDuty[15:8] : 8'h00);
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        bufDuty    <= sxpw_pkg::RST_WORD;
        activeDuty <= sxpw_pkg::RST_WORD;
      end else begin
        if (apbWrite & hitLo) begin
          bufDuty[7:0] <= wByte;
        end
        if (apbWrite & hitHi) begin
          bufDuty[15:8] <= wByte;
        end
        if (loadNow) begin
          activeDuty <= bufDuty;
        end
      end
    end
  end
  // Group mode reroutes 2,4 to duty 0 and 3,5 to duty 1
  assign wif.duty[0] = ch[0].activeDuty;
  assign wif.duty[1] = ch[1].activeDuty;
  assign wif.duty[2] = groupMode ? ch[0].activeDuty : ch[2].activeDuty;
  assign wif.duty[3] = groupMode ? ch[1].activeDuty : ch[3].activeDuty;
  assign wif.duty[4] = groupMode ? ch[0].activeDuty : ch[4].activeDuty;
  assign wif.duty[5] = groupMode ? ch[1].activeDuty : ch[5].activeDuty;
  assign wif.count   = count;
  assign rawWave     = wif.wave;

  // ==========================================================================
  // Read mux
  wire [7:0] runRead = {runEnable, loadPending, generatorFlag, clearPending, 4'h0};
  wire       regHit  = addrInMap & (hitClk | hitRun | hitMode | hitPerLo | hitPerHi |
                                    hitPin | hitStat | hitMask | dutyHitAcc[6]);
  wire [7:0] readByte = hitClk   ? clockSourceControl :
                        hitRun   ? runRead :
                        hitMode  ? modeConfig :
                        hitPerLo ? bufPeriod[7:0] :
                        hitPerHi ? bufPeriod[15:8] :
                        hitPin   ? {2'h0, pinFunctionSelect} :
                        hitStat  ? {6'h00, irqStatus} :
                        hitMask  ? {6'h00, irqMask} : dutyReadAcc[6];

  // ==========================================================================
  // Bus answer: one wait-free access phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~regHit;
      prdata  <= (apbSetup & regHit) ? {24'h000000, readByte} : 32'h00000000;
    end
  end

  // ==========================================================================
  // Configuration writes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clockSourceControl <= sxpw_pkg::RST_BYTE;
      modeConfig         <= sxpw_pkg::RST_BYTE;
      bufPeriod          <= sxpw_pkg::RST_WORD;
      pinFunctionSelect  <= sxpw_pkg::RST_PINS;
      irqMask            <= sxpw_pkg::RST_IRQ;
      runEnable          <= 1'b0;
    end else if (apbWrite & regHit) begin
      if (hitClk) begin
        clockSourceControl <= wByte & sxpw_pkg::CLOCK_SOURCE_RW_MASK;
      end
      if (hitMode) begin
        modeConfig <= wByte;
      end
      if (hitPerLo) begin
        bufPeriod[7:0] <= wByte;
      end
      if (hitPerHi) begin
        bufPeriod[15:8] <= wByte;
      end
      if (hitPin) begin
        pinFunctionSelect <= wByte[5:0];
      end
      if (hitMask) begin
        irqMask <= wByte[1:0];
      end
      if (hitRun) begin
        runEnable <= wByte[sxpw_pkg::BIT_RUN_ENABLE];
      end
    end
  end

  // ==========================================================================
  // Self-clearing bits, flag and counter
  wire runWr = apbWrite & hitRun & addrInMap;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      loadPending   <= 1'b0;
      clearPending  <= 1'b0;
      generatorFlag <= 1'b0;
      count         <= sxpw_pkg::RST_WORD;
      activePeriod  <= sxpw_pkg::RST_WORD;
      irqStatus     <= sxpw_pkg::RST_IRQ;
    end else begin
      count     <= next_count;
      irqStatus <= next_irqStatus;
      if (runWr & wByte[sxpw_pkg::BIT_COUNTER_CLEAR]) begin
        clearPending <= 1'b1;
      end else begin
        clearPending <= 1'b0;
      end
      if (runWr & wByte[sxpw_pkg::BIT_LOAD]) begin
        loadPending <= 1'b1;
      end else if (loadNow) begin
        loadPending <= 1'b0;
      end
      if (loadNow) begin
        activePeriod <= bufPeriod;
      end
      // Hardware set wins over a software clear in the same cycle
      if (wrapNow) begin
        generatorFlag <= 1'b1;
      end else if (runWr & ~wByte[sxpw_pkg::BIT_GENERATOR_FLAG]) begin
        generatorFlag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Pin mux and interrupt
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pinOut <= sxpw_pkg::RST_PINS;
      irq    <= 1'b0;
    end else begin
      pinOut <= (pinFunctionSelect & wif.wave) | (~pinFunctionSelect & gpioOut);
      irq    <= |(irqStatus & irqMask);
    end
  end

  sxpw_prescaler u_prescaler (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .srcSelect      (clockSourceControl[sxpw_pkg::BIT_CLOCK_SOURCE_SELECT]),
    .timer1Overflow (timer1Overflow),
    .prescale       (modeConfig[2:0]),
    .tick           (tick)
  );

  sxpw_compare u_compare (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wif      (wif)
  );

  // ==========================================================================
  // Checks
  property p_clear_done;
    @(posedge core_clk) disable iff (!rst_n)
    clearPending |=> count == 16'h0000 ##1 !clearPending || $past(runWr);
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("counter not cleared after clear request");

  property p_idle_holds;
    @(posedge core_clk) disable iff (!rst_n)
    !runEnable && !clearPending |=> count == $past(count);
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("counter moved while idle");

  property p_wrap_zero;
    @(posedge core_clk) disable iff (!rst_n)
    wrapNow |=> count == 16'h0000 && generatorFlag;
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("wrap did not zero counter or set flag");

  property p_load_at_wrap;
    @(posedge core_clk) disable iff (!rst_n)
    loadPending && wrapNow && !runWr |=> activePeriod == $past(bufPeriod) && !loadPending;
  endproperty
  a_load_at_wrap: assert property (p_load_at_wrap) else $error("load did not transfer at wrap");

  property p_no_early_load;
    @(posedge core_clk) disable iff (!rst_n)
    !loadNow |=> $stable(activePeriod) && $stable(ch[0].activeDuty);
  endproperty
  a_no_early_load: assert property (p_no_early_load) else $error("active value changed without load");

  property p_load_reads_pending;
    @(posedge core_clk) disable iff (!rst_n)
    runWr && wByte[6] |=> loadPending;
  endproperty
  a_load_reads_pending: assert property (p_load_reads_pending) else $error("load bit not pending after write");

  property p_group_map;
    @(posedge core_clk) disable iff (!rst_n)
    groupMode |-> wif.duty[4] == ch[0].activeDuty && wif.duty[5] == ch[1].activeDuty;
  endproperty
  a_group_map: assert property (p_group_map) else $error("group mode duty mapping wrong");

  property p_irq_level;
    @(posedge core_clk) disable iff (!rst_n)
    ##1 irq == $past(|(irqStatus & irqMask));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output disagrees with status");

  property p_ready_one_cycle;
    @(posedge core_clk) disable iff (!rst_n)
    pready |=> !pready;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("bus answer held past one cycle");

  property p_flag_sticky;
    @(posedge core_clk) disable iff (!rst_n)
    generatorFlag && !runWr |=> generatorFlag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without software clear");

  property p_group_waves;
    @(posedge core_clk) disable iff (!rst_n)
    groupMode |=> rawWave[2] == rawWave[0] && rawWave[4] == rawWave[0] &&
                  rawWave[3] == rawWave[1] && rawWave[5] == rawWave[1];
  endproperty
  a_group_waves: assert property (p_group_waves) else $error("group mode waves differ");
endmodule
`default_nettype wire

// ---- sxpw_switch_stage.sv ----
// Output control stage model driving the power switches
`timescale 1ns/10ps
`default_nettype none
module sxpw_switch_stage (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Pins from the core
  input  wire logic [5:0] pinOut,
  input  wire logic [5:0] pinFunctionSelect,
  // Switch gates
  output logic      [5:0] switchOn
);
  // Only pins handed to the generator reach a gate; pin modes stay untouched
  always_ff @(posedge core_clk) begin
    if (!rst_n) switchOn <= 6'h00;
    else switchOn <= pinOut & pinFunctionSelect;
  end
endmodule
`default_nettype wire

// ---- test_sxpw_core.sv ----
// Self-checking bench of the six-channel generator core
`timescale 1ns/10ps
`default_nettype none
module test_sxpw_core;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic [31:0] rdData;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        t1En = 1'b0;
  logic        timer1Overflow = 1'b0;
  logic [5:0]  gpioOut = 6'h00;
  logic [5:0]  rawWave;
  logic [5:0]  pinOut;
  logic [5:0]  pinFunctionSelect;
  logic [5:0]  switchOn;
  logic [5:0]  pRaw;
  logic [5:0]  pGp;
  logic [5:0]  pPin;
  logic [31:0] rng = 32'd55;
  int          nFail = 0;
  int          totalChecks = 0;
  int          cyc = 0;
  logic [31:0] expData [$];
  logic        expErr [$];
  logic        expCmp [$];
  logic [15:0] duty [6];
  logic [15:0] prev [6];
  int          hi [6];

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) timer1Overflow <= t1En & ~timer1Overflow;

  sxpw_core sxpw_core_i (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer1Overflow(timer1Overflow), .gpioOut(gpioOut), .rawWave(rawWave), .pinOut(pinOut),
    .pinFunctionSelect(pinFunctionSelect), .irq(irq)
  );
  sxpw_switch_stage sxpw_switch_stage_i (
    .core_clk(core_clk), .rst_n(rst_n), .pinOut(pinOut),
    .pinFunctionSelect(pinFunctionSelect), .switchOn(switchOn)
  );

  // ==========
  // Helpers
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      nFail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // ==========
  // Bus master and read monitor
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic cmp,
                     input logic [7:0] ed, input logic err);
    expCmp.push_back(cmp & ~wr);
    expData.push_back({24'h000000, ed});
    expErr.push_back(err);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdData = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 1'b0, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00, 1'b1, e, 1'b0);
  endtask

  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && expErr.size() > 0) begin
      chk({31'h0, pslverr}, {31'h0, expErr[0]}, "error flag");
      if (expCmp[0]) chk(prdata, expData[0], "read data");
      void'(expErr.pop_front());
      void'(expCmp.pop_front());
      void'(expData.pop_front());
    end
    cyc++;
    if (cyc == 30000) begin
      nFail++;
      summarize();
    end
  end

  // ==========
  // Waveform helpers
  task automatic writeValues();
    wr(sxpw_pkg::IDX_PERIOD_HIGH_BYTE, 8'h00);
    wr(sxpw_pkg::IDX_PERIOD_LOW_BYTE, 8'h09);
    for (int i = 0; i < 6; i++) begin
      rng = xorshift(rng);
      duty[i] = 16'(rng % 12);
      wr(sxpw_pkg::IDX_DUTY_HIGH_BYTE[i], duty[i][15:8]);
      wr(sxpw_pkg::IDX_DUTY_LOW_BYTE[i], duty[i][7:0]);
    end
  endtask

  task automatic loadWait(input logic [7:0] ctl);
    int n;
    n = 0;
    wr(sxpw_pkg::IDX_PWM_RUN_CONTROL, ctl | 8'h40);
    rdData = 32'h40;
    while (rdData[6] === 1'b1 && n < 100) begin
      apb(1'b0, sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'h00, 1'b0, 8'h00, 1'b0);
      n++;
    end
    chk({31'h0, rdData[6]}, 32'h0, "load done");
  endtask

  task automatic measure(input int w);
    for (int i = 0; i < 6; i++) hi[i] = 0;
    repeat (w) begin
      @(negedge core_clk);
      // Unknown wave level spoils the count
      for (int i = 0; i < 6; i++) hi[i] += (rawWave[i] === 1'b1) ? 1 : ((rawWave[i] === 1'b0) ? 0 : 1000);
    end
  endtask

  // Period of ten ticks; a duty above it keeps the wave high
  task automatic chkWaves(input logic [15:0] d [6], input int scale, input logic grp);
    int e;
    for (int i = 0; i < 6; i++) begin
      e = (grp && i >= 2) ? d[i % 2] : d[i];
      e = (e > 10) ? 10 : e;
      chk(hi[i], 2 * scale * e, "high time");
    end
  endtask

  task automatic chkFrozen(input int w);
    for (int i = 0; i < 6; i++) chk(hi[i] == 0 || hi[i] == w, 1, "frozen wave");
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(sxpw_pkg::IDX_CLOCK_SOURCE_CONTROL, 8'h00);
    rd(sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'h00);
    rd(sxpw_pkg::IDX_PWM_MODE_CONFIG, 8'h00);
    apb(1'b0, 8'h00, 8'h00, 1'b1, 8'h00, 1'b1);
    apb(1'b1, 8'h00, 8'hff, 1'b0, 8'h00, 1'b1);
    wr(sxpw_pkg::IDX_CLOCK_SOURCE_CONTROL, 8'hff);
    rd(sxpw_pkg::IDX_CLOCK_SOURCE_CONTROL, 8'h5a);
    wr(sxpw_pkg::IDX_CLOCK_SOURCE_CONTROL, 8'h00);
    wr(sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'h10);
    writeValues();
    rd(sxpw_pkg::IDX_PERIOD_LOW_BYTE, 8'h09);
    measure(20);
    for (int i = 0; i < 6; i++) chk(hi[i], 0, "idle wave");
    loadWait(8'h80);
    repeat (20) @(posedge core_clk);
    measure(20);
    chkWaves(duty, 1, 1'b0);
    rd(sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'ha0);
    prev = duty;
    writeValues();
    measure(20);
    chkWaves(prev, 1, 1'b0);
    loadWait(8'h80);
    repeat (20) @(posedge core_clk);
    measure(20);
    chkWaves(duty, 1, 1'b0);
    wr(sxpw_pkg::IDX_PWM_MODE_CONFIG, 8'h20);
    repeat (20) @(posedge core_clk);
    measure(20);
    chkWaves(duty, 1, 1'b1);
    for (int c = 0; c < 8; c++) begin
      wr(sxpw_pkg::IDX_PWM_MODE_CONFIG, 8'(c));
      repeat (20 << c) @(posedge core_clk);
      measure(20 << c);
      chkWaves(duty, 1 << c, 1'b0);
    end
    wr(sxpw_pkg::IDX_PWM_MODE_CONFIG, 8'h00);
    t1En <= 1'b1;
    wr(sxpw_pkg::IDX_CLOCK_SOURCE_CONTROL, 8'h40);
    repeat (40) @(posedge core_clk);
    measure(40);
    chkWaves(duty, 2, 1'b0);
    t1En <= 1'b0;
    repeat (4) @(posedge core_clk);
    measure(40);
    chkFrozen(40);
    wr(sxpw_pkg::IDX_CLOCK_SOURCE_CONTROL, 8'h00);
    wr(sxpw_pkg::IDX_IRQ_MASK, 8'h01);
    repeat (3) @(negedge core_clk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(sxpw_pkg::IDX_IRQ_MASK, 8'h00);
    rd(sxpw_pkg::IDX_IRQ_STATUS, 8'h03);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'h00);
    // A wrap in the stopping write wins over the flag clear
    wr(sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'h00);
    rd(sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'h00);
    wr(sxpw_pkg::IDX_IRQ_STATUS, 8'h03);
    rd(sxpw_pkg::IDX_IRQ_STATUS, 8'h00);
    measure(30);
    chkFrozen(30);
    wr(sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'h10);
    rd(sxpw_pkg::IDX_PWM_RUN_CONTROL, 8'h00);
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 6; i++) chk({31'h0, rawWave[i]}, {31'h0, duty[i] != 16'h0}, "cleared");
    wr(sxpw_pkg::IDX_IRQ_MASK, 8'h02);
    loadWait(8'h80);
    repeat (3) @(negedge core_clk);
    chk({31'h0, irq}, 32'h1, "load irq");
    wr(sxpw_pkg::IDX_PIN_FUNCTION_SELECT, 8'h15);
    rd(sxpw_pkg::IDX_PIN_FUNCTION_SELECT, 8'h15);
    chk({26'h0, pinFunctionSelect}, 32'h15, "pin select");
    for (int k = 0; k < 30; k++) begin
      @(posedge core_clk);
      rng = xorshift(rng);
      gpioOut <= rng[5:0];
      @(negedge core_clk);
      if (k > 0) chk({26'h0, pinOut}, {26'h0, (pRaw & 6'h15) | (pGp & 6'h2a)}, "pin mux");
      if (k > 0) chk({26'h0, switchOn}, {26'h0, pPin & 6'h15}, "switch gate");
      pRaw = rawWave;
      pGp = gpioOut;
      pPin = pinOut;
    end
    // Buffer-only writes, no load requested
    wr(sxpw_pkg::IDX_DUTY_HIGH_BYTE[5], 8'ha5);
    rd(sxpw_pkg::IDX_DUTY_HIGH_BYTE[5], 8'ha5);
    wr(sxpw_pkg::IDX_PERIOD_HIGH_BYTE, 8'h3c);
    rd(sxpw_pkg::IDX_PERIOD_HIGH_BYTE, 8'h3c);
    summarize();
  end
endmodule
`default_nettype wire
